// ### src/agc_regs.svh
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH

// ********************************************
// Register map
// ********************************************
`define AGC_CAP_WORD_OFF    12'h010
`define AGC_WORD_RESET      64'h0000000000000000

// ********************************************
// Field positions of the capability word
// ********************************************
`define AGC_MAXXFER_MSB     20
`define AGC_MAXXFER_LSB     16
`define AGC_DRAIN_RB_BIT    9
`define AGC_DST_RB_BIT      8
`define AGC_INTH_REQ_BIT    7
`define AGC_CC_FLUSH_BIT    3
`define AGC_CC_MEM_BIT      2
`define AGC_OVERLAP_BIT     1
`define AGC_BOF_BIT         0
`define AGC_UPPER_LSB       21

// ********************************************
// Timing
// ********************************************
`define AGC_RSP_CYCLES      1

`endif

// ### src/agc_pkg.sv
package agc_pkg;

  typedef logic [63:0] agc_word_t;

  typedef enum logic [1:0] {
    AGC_IDLE = 2'b01,
    AGC_RESP = 2'b10
  } agc_rsp_t;

endpackage

// ### src/agc_cap_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "agc_regs.svh"

// What this block does
// - The capability word is a 64-bit read-only register at offset 0x10.
// - Bits 20:16 hold N, and the largest transfer any queue may take is 2^N.
// - With bit 9 clear, drain readback addresses and their flags are ignored.
// - With bit 9 set, each drain readback whose valid flag is set is issued.
// - Bit 8 says whether the destination readback flag is honoured.
// - With bit 7 clear, the descriptor's interrupt handle is the table index.
// - Bit 3 says whether the flush cache-control flag decides eviction.
// - Bit 2 says whether the write cache-control flag governs cache use.
// - Bit 1 clear makes any overlap an error; set lets memory move overlap.
// - Overlap is always an error for operations other than memory move.
// - Bit 0 clear makes every page fault stop the operation and report it.
// - Bit 0 set lets queue enable and descriptor flag choose fault blocking.
module agc_cap_reg #(
  parameter int          ADDR_W       = 12,
  parameter int          RB_N         = 2,
  parameter int          HANDLE_W     = 11,
  parameter logic [4:0]  MAX_XFER_EXP = 5'h15,
  parameter logic        CAP_DRAIN_RB = 1'b1,
  parameter logic        CAP_DST_RB   = 1'b1,
  parameter logic        CAP_INTH_REQ = 1'b0,
  parameter logic        CAP_CC_FLUSH = 1'b1,
  parameter logic        CAP_CC_MEM   = 1'b1,
  parameter logic        CAP_OVERLAP  = 1'b1,
  parameter logic        CAP_BOF      = 1'b1,
  parameter logic [42:0] UPPER_FIELDS = 43'h0
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [63:0]           reg_wdata,
  output logic                       reg_ack,
  output logic [63:0]                reg_rdata,
  output logic [4:0]                 max_xfer_exp,
  input  wire logic                  chk_valid,
  input  wire logic                  chk_is_move,
  input  wire logic                  chk_is_flush,
  input  wire logic                  chk_is_write,
  input  wire logic                  chk_overlap,
  input  wire logic                  chk_cache_ctl,
  input  wire logic                  chk_dst_rb,
  input  wire logic [RB_N-1:0]       chk_rb_valid,
  input  wire logic [HANDLE_W-1:0]   chk_handle,
  input  wire logic                  chk_queue_bof_en,
  input  wire logic                  chk_desc_bof,
  input  wire logic                  chk_page_fault,
  output logic                       res_valid_q,
  output logic [RB_N-1:0]            rb_issue_q,
  output logic                       dst_rb_q,
  output logic                       flush_evict_q,
  output logic                       write_cc_q,
  output logic                       overlap_err_q,
  output logic                       fault_block_q,
  output logic                       fault_report_q,
  output logic                       handle_is_index_q,
  output logic [HANDLE_W-1:0]        handle_index_q
);

  // ********************************************
  // Parameter checks
  // ********************************************
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 5 to 32");
  end
  if (RB_N < 1 || RB_N > 8) begin : g_bad_rb
    $error("RB_N must be 1 to 8");
  end
  if (HANDLE_W < 1 || HANDLE_W > 16) begin : g_bad_handle
    $error("HANDLE_W must be 1 to 16");
  end

  // ********************************************
  // Capability word
  // ********************************************
  agc_pkg::agc_word_t cap_word;
  agc_pkg::agc_rsp_t  rsp_q;
  agc_pkg::agc_rsp_t  rsp_d;
  logic               hit;

  function automatic agc_pkg::agc_word_t build_word();
    agc_pkg::agc_word_t w;
    w = `AGC_WORD_RESET;
    w[63:`AGC_UPPER_LSB] = UPPER_FIELDS;
    w[`AGC_MAXXFER_MSB:`AGC_MAXXFER_LSB] = MAX_XFER_EXP;
    w[`AGC_DRAIN_RB_BIT] = CAP_DRAIN_RB;
    w[`AGC_DST_RB_BIT]   = CAP_DST_RB;
    w[`AGC_INTH_REQ_BIT] = CAP_INTH_REQ;
    w[`AGC_CC_FLUSH_BIT] = CAP_CC_FLUSH;
    w[`AGC_CC_MEM_BIT]   = CAP_CC_MEM;
    w[`AGC_OVERLAP_BIT]  = CAP_OVERLAP;
    w[`AGC_BOF_BIT]      = CAP_BOF;
    return w;
  endfunction

  // Unused ranges are never set, so they read as zero
  assign cap_word     = build_word();
  assign max_xfer_exp = cap_word[`AGC_MAXXFER_MSB:`AGC_MAXXFER_LSB];
  assign hit = (reg_addr == ADDR_W'(`AGC_CAP_WORD_OFF));

  // ********************************************
  // Register port
  // ********************************************
  always_comb begin
    case (rsp_q)
      agc_pkg::AGC_IDLE: begin
        rsp_d = (reg_rd || reg_wr) ? agc_pkg::AGC_RESP : agc_pkg::AGC_IDLE;
      end
      agc_pkg::AGC_RESP: begin
        rsp_d = agc_pkg::AGC_IDLE;
      end
      default: begin
        rsp_d = agc_pkg::AGC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= agc_pkg::AGC_IDLE;
    end else if (clk_en) begin
      rsp_q <= rsp_d;
    end
  end

  assign reg_ack = (rsp_q == agc_pkg::AGC_RESP);

  // Writes are acknowledged but discarded; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `AGC_WORD_RESET;
    end else if (clk_en && rsp_q == agc_pkg::AGC_IDLE) begin
      if (reg_rd && hit) begin
        reg_rdata <= cap_word;
      end else begin
        reg_rdata <= `AGC_WORD_RESET;
      end
    end
  end

  // ********************************************
  // Descriptor feature gating
  // ********************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_q <= 1'b0;
    end else if (clk_en) begin
      res_valid_q <= chk_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rb_issue_q <= '0;
      dst_rb_q   <= 1'b0;
    end else if (clk_en && chk_valid) begin
      // Flags are reserved when unsupported, so mask them off
      rb_issue_q <= cap_word[`AGC_DRAIN_RB_BIT] ? chk_rb_valid
                                                : '0;
      dst_rb_q   <= cap_word[`AGC_DST_RB_BIT] & chk_dst_rb;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flush_evict_q <= 1'b0;
      write_cc_q    <= 1'b0;
    end else if (clk_en && chk_valid) begin
      flush_evict_q <= cap_word[`AGC_CC_FLUSH_BIT] & chk_is_flush
                       & chk_cache_ctl;
      write_cc_q    <= cap_word[`AGC_CC_MEM_BIT] & chk_is_write
                       & chk_cache_ctl;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overlap_err_q <= 1'b0;
    end else if (clk_en && chk_valid) begin
      overlap_err_q <= chk_overlap & (~chk_is_move
                       | ~cap_word[`AGC_OVERLAP_BIT]);
    end
  end

  // Without support the queue enable and descriptor flag are reserved
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_block_q  <= 1'b0;
      fault_report_q <= 1'b0;
    end else if (clk_en && chk_valid) begin
      fault_block_q  <= chk_page_fault & cap_word[`AGC_BOF_BIT]
                        & chk_queue_bof_en & chk_desc_bof;
      fault_report_q <= chk_page_fault & ~(cap_word[`AGC_BOF_BIT]
                        & chk_queue_bof_en & chk_desc_bof);
    end
  end

  // Opaque handles come from software's earlier request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      handle_is_index_q <= 1'b0;
      handle_index_q    <= '0;
    end else if (clk_en && chk_valid) begin
      handle_is_index_q <= ~cap_word[`AGC_INTH_REQ_BIT];
      handle_index_q    <= chk_handle;
    end
  end

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  read_word_a: assert property (
    (clk_en && reg_rd && hit && rsp_q == agc_pkg::AGC_IDLE)
      |=> (reg_rdata == cap_word))
    else $error("capability read returned wrong word");

  reserved_zero_a: assert property (
    reg_ack |-> (reg_rdata[15:10] == 6'h00 && reg_rdata[6:4] == 3'h0))
    else $error("unused capability bits not zero");

  ack_once_a: assert property (
    (clk_en && (reg_rd || reg_wr) && rsp_q == agc_pkg::AGC_IDLE)
      |=> reg_ack ##1 !reg_ack)
    else $error("register ack not a single pulse");

  xfer_exp_a: assert property (
    reg_ack && reg_rdata != 64'h0
      |-> (reg_rdata[20:16] == max_xfer_exp))
    else $error("transfer exponent mismatch");

  drain_rb_a: assert property (
    (clk_en && chk_valid && !cap_word[9]) |=> (rb_issue_q == '0))
    else $error("readback issued while unsupported");

  drain_issue_a: assert property (
    (clk_en && chk_valid && cap_word[9])
      |=> (rb_issue_q == $past(chk_rb_valid)))
    else $error("readback flags not honoured");

  dst_rb_a: assert property (
    (clk_en && chk_valid)
      |=> (dst_rb_q == (cap_word[8] && $past(chk_dst_rb))))
    else $error("destination readback gating wrong");

  handle_mode_a: assert property (
    (clk_en && chk_valid) |=> (handle_is_index_q == !cap_word[7]
      && handle_index_q == $past(chk_handle)))
    else $error("interrupt handle mode wrong");

  flush_cc_a: assert property (
    (clk_en && chk_valid && !(cap_word[3] && chk_is_flush)) |=> !flush_evict_q)
    else $error("flush cache flag used while ignored");

  write_cc_a: assert property (
    (clk_en && chk_valid && !(cap_word[2] && chk_is_write)) |=> !write_cc_q)
    else $error("write cache flag used while ignored");

  flush_evict_a: assert property (
    (clk_en && chk_valid && cap_word[`AGC_CC_FLUSH_BIT] && chk_is_flush)
      |=> (flush_evict_q == $past(chk_cache_ctl)))
    else $error("flush cache flag not followed");

  write_cc_use_a: assert property (
    (clk_en && chk_valid && cap_word[`AGC_CC_MEM_BIT] && chk_is_write)
      |=> (write_cc_q == $past(chk_cache_ctl)))
    else $error("write cache flag not followed");

  move_overlap_a: assert property (
    (clk_en && chk_valid && chk_is_move && cap_word[`AGC_OVERLAP_BIT])
      |=> !overlap_err_q)
    else $error("memory move overlap refused");

  overlap_err_a: assert property (
    (clk_en && chk_valid && chk_overlap && !cap_word[1])
      |=> (res_valid_q && overlap_err_q))
    else $error("overlap not flagged");

  nonmove_ovl_a: assert property (
    (clk_en && chk_valid && chk_overlap && !chk_is_move) |=> overlap_err_q)
    else $error("non-move overlap accepted");

  fault_stop_a: assert property (
    (clk_en && chk_valid && chk_page_fault && !cap_word[0])
      |=> (fault_report_q && !fault_block_q))
    else $error("fault not reported");

  fault_block_a: assert property (
    (clk_en && chk_valid && chk_page_fault && cap_word[0]
      && chk_queue_bof_en && chk_desc_bof)
      |=> (fault_block_q && !fault_report_q))
    else $error("fault not blocked");

  freeze_a: assert property (
    !clk_en |=> ($stable(reg_rdata) && $stable(res_valid_q)))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ### sim/accel_general_capability_reg_tb.sv
`timescale 1ns/10ps
`default_nettype none
module accel_general_capability_reg_tb;
  // Word for the default capabilities: only the handle request bit clear
  localparam logic [63:0] EXP_WORD = {43'h0, 5'h15, 6'h0, 2'b11, 1'b0,
                                      3'h0, 4'hf};
  // Second build: every feature flipped, handle request required
  localparam logic [63:0] ALT_WORD = {43'h0, 5'h0c, 6'h0, 2'b00, 1'b1,
                                      3'h0, 4'h0};
  logic        clock;
  logic        rst_n;
  logic        clk_en;
  logic        reg_rd;
  logic        reg_wr;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata;
  logic        reg_ack;
  logic [63:0] reg_rdata;
  logic [4:0]  max_xfer_exp;
  logic        chk_valid;
  logic [11:0] attr;
  logic [10:0] chk_handle;
  logic [9:0]  res;
  logic [10:0] handle_index_q;
  logic [63:0] d;
  logic        reg_ack_b;
  logic [63:0] reg_rdata_b;
  logic [4:0]  max_xfer_exp_b;
  logic [9:0]  res_b;
  logic [10:0] handle_index_b;
  int          mismatches;
  int          checks;

  agc_cap_reg i_agc_cap_reg (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .max_xfer_exp(max_xfer_exp),
    .chk_valid(chk_valid), .chk_is_move(attr[11]), .chk_is_flush(attr[10]),
    .chk_is_write(attr[9]), .chk_overlap(attr[8]), .chk_cache_ctl(attr[7]),
    .chk_dst_rb(attr[6]), .chk_rb_valid(attr[5:4]),
    .chk_handle(chk_handle), .chk_queue_bof_en(attr[3]),
    .chk_desc_bof(attr[2]), .chk_page_fault(attr[1]),
    .res_valid_q(res[9]), .rb_issue_q(res[8:7]), .dst_rb_q(res[6]),
    .flush_evict_q(res[5]), .write_cc_q(res[4]), .overlap_err_q(res[3]),
    .fault_block_q(res[2]), .fault_report_q(res[1]),
    .handle_is_index_q(res[0]), .handle_index_q(handle_index_q)
  );

  // Same stimulus into a build with the features turned the other way
  if (1) begin : g_alt
    agc_cap_reg #(
      .MAX_XFER_EXP(5'h0c), .CAP_DRAIN_RB(1'b0), .CAP_DST_RB(1'b0),
      .CAP_INTH_REQ(1'b1), .CAP_CC_FLUSH(1'b0), .CAP_CC_MEM(1'b0),
      .CAP_OVERLAP(1'b0), .CAP_BOF(1'b0)
    ) i_agc_cap_reg (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_ack(reg_ack_b), .reg_rdata(reg_rdata_b),
      .max_xfer_exp(max_xfer_exp_b),
      .chk_valid(chk_valid), .chk_is_move(attr[11]), .chk_is_flush(attr[10]),
      .chk_is_write(attr[9]), .chk_overlap(attr[8]), .chk_cache_ctl(attr[7]),
      .chk_dst_rb(attr[6]), .chk_rb_valid(attr[5:4]),
      .chk_handle(chk_handle), .chk_queue_bof_en(attr[3]),
      .chk_desc_bof(attr[2]), .chk_page_fault(attr[1]),
      .res_valid_q(res_b[9]), .rb_issue_q(res_b[8:7]), .dst_rb_q(res_b[6]),
      .flush_evict_q(res_b[5]), .write_cc_q(res_b[4]),
      .overlap_err_q(res_b[3]), .fault_block_q(res_b[2]),
      .fault_report_q(res_b[1]), .handle_is_index_q(res_b[0]),
      .handle_index_q(handle_index_b)
    );
  end

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Holds the request until the answer is seen, then releases it
  task automatic reg_op(input logic wr, input logic [11:0] a,
                        output logic [63:0] q);
    int n;
    n = 0;
    @(posedge clock);
    reg_rd   <= ~wr;
    reg_wr   <= wr;
    reg_addr <= a;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (reg_ack !== 1'b1 && n < 10);
    if (n >= 10) begin
      mismatches++;
      $display("CHECK FAILED t=%0t no register answer", $time);
      results();
    end
    chk(reg_ack_b, 1'b1);
    q = reg_rdata;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk(reg_ack, 1'b0);
    chk(reg_ack_b, 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    chk(max_xfer_exp, 5'h15);
    chk(max_xfer_exp_b, 5'h0c);
    reg_op(1'b0, 12'h010, d);
    chk(d, EXP_WORD);
    chk(reg_rdata_b, ALT_WORD);
    chk(d[20:16], 5'h15);
    chk({d[15:10], d[6:4]}, 9'h000);
    reg_op(1'b1, 12'h010, d);
    chk(d, 64'h0);
    chk(reg_rdata_b, 64'h0);
    reg_op(1'b0, 12'h010, d);
    chk(d, EXP_WORD);
    chk(reg_rdata_b, ALT_WORD);
    reg_op(1'b0, 12'h018, d);
    chk(d, 64'h0);
    chk(reg_rdata_b, 64'h0);
    $display("test regs done");
  endtask

  // Back-to-back descriptors; each result is checked one edge later
  task automatic test_desc();
    logic [11:0] tab [10];
    logic [11:0] a;
    logic [9:0]  e;
    logic [9:0]  eb;
    tab = '{12'h100, 12'h900, 12'h480, 12'h400, 12'h280,
            12'h070, 12'h010, 12'h00e, 12'h00a, 12'h002};
    for (int i = 0; i <= 10; i++) begin
      @(posedge clock);
      chk_valid  <= (i < 10);
      attr       <= (i < 10) ? tab[i] : 12'h000;
      chk_handle <= 11'(i * 37);
      #1;
      if (i > 0) begin
        a = tab[i-1];
        e = {1'b1, a[5:4], a[6], a[10] & a[7], a[9] & a[7],
             a[8] & ~a[11], a[1] & a[3] & a[2],
             a[1] & ~(a[3] & a[2]), 1'b1};
        chk(res[9:7], e[9:7]);
        chk(res[6], e[6]);
        chk(res[5], e[5]);
        chk(res[4], e[4]);
        chk(res[3], e[3]);
        chk(res[2:1], e[2:1]);
        chk(res[0], e[0]);
        chk(handle_index_q, 11'((i - 1) * 37));
        // Flipped build: no readbacks, no cache control, no overlap
        eb = {1'b1, 2'b00, 1'b0, 1'b0, 1'b0, a[8], 1'b0, a[1], 1'b0};
        chk(res_b[9:7], eb[9:7]);
        chk(res_b[6:4], eb[6:4]);
        chk(res_b[3], eb[3]);
        chk(res_b[2:1], eb[2:1]);
        chk(res_b[0], eb[0]);
        chk(handle_index_b, 11'((i - 1) * 37));
      end
    end
    @(posedge clock);
    #1;
    chk(res[9], 1'b0);
    $display("test desc done");
  endtask

  // Clock enable low must freeze the result flops
  task automatic test_freeze();
    @(posedge clock);
    clk_en    <= 1'b0;
    chk_valid <= 1'b1;
    attr      <= 12'h100;
    repeat (2) @(posedge clock);
    #1;
    chk(res[9], 1'b0);
    chk(res[3], 1'b0);
    @(posedge clock);
    clk_en    <= 1'b1;
    chk_valid <= 1'b0;
    $display("test freeze done");
  endtask

  initial begin
    mismatches = 0;
    checks     = 0;
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    reg_rd     = 1'b0;
    reg_wr     = 1'b0;
    reg_addr   = 12'h000;
    reg_wdata  = 64'hffffffffffffffff;
    chk_valid  = 1'b0;
    attr       = 12'h000;
    chk_handle = 11'h000;
    repeat (11) @(posedge clock);
    #1;
    chk(reg_ack, 1'b0);
    chk(reg_rdata, 64'h0);
    chk(res, 10'h000);
    chk(res_b, 10'h000);
    @(posedge clock);
    rst_n <= 1'b1;
    test_regs();
    test_desc();
    test_freeze();
    results();
  end
endmodule
`default_nettype wire
